// file: verilog/rcs_spi_slave.sv
/*
  Four-wire serial slave of a radio transceiver: configuration registers,
  status registers, command strobes, power table and both data FIFOs.
  Assumes the serial pins come from a host on its own clock, and that the
  radio main state, oscillator status and radio data run on mclk_in.
*/
`timescale 1ns/100ps
module rcs_spi_slave
  import rcs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic sclk_in,
  input wire logic chip_select_n_in,
  input wire logic si_in,
  output logic shared_output_pin_out,
  output logic shared_output_pin_oe_n_out,
  input wire logic gp_level_in,
  input wire logic gp_oe_n_in,
  input wire logic [2:0] main_state_in,
  input wire logic osc_stable_in,
  input wire logic sleep_entry_in,
  input wire logic [STAT_NUM*8-1:0] status_regs_in,
  output logic [CFG_NUM*8-1:0] cfg_regs_out,
  output logic [3:0] strobe_code_out,
  output logic strobe_valid_out,
  input wire logic [2:0] power_entry_select_in,
  input wire logic ook_mode_in,
  input wire logic ook_bit_in,
  output logic [7:0] pa_level_out,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in
);
  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic [2:0] sclk_sy_r;
  logic [2:0] cs_sy_r;
  logic [1:0] si_sy_r;
  rcs_phase_t phase_r;
  rcs_access_t acc_r;
  logic [2:0] bitcnt_r;
  logic [6:0] sh_r;
  logic rw_r;
  logic burst_r;
  logic [5:0] addr_r;
  logic use_stat_r;
  logic [7:0] out_r;
  logic [2:0] pa_idx_r;
  logic [7:0] cfg_r [CFG_NUM];
  logic [7:0] pa_r [PA_DEPTH];
  logic so_r;
  logic so_oe_n_r;
  logic [7:0] pa_level_r;
  logic strobe_valid_r;
  logic [3:0] strobe_code_r;
  logic pend_r;
  logic [3:0] pend_code_r;
  logic tx_flush_r;
  logic rx_flush_r;
  logic tx_push_r;
  logic [7:0] tx_wdata_r;
  logic [FIFO_AW:0] tx_cnt;
  logic [FIFO_AW:0] rx_cnt;

  rcs_stream_if spi_tx ();
  rcs_stream_if tx_buf ();
  rcs_stream_if tx_out ();
  rcs_stream_if rx_in ();
  rcs_stream_if rx_buf ();
  rcs_stream_if rx_rd ();

  // ********************************************************************
  // Pin synchronisers and edge detection
  // ********************************************************************
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sclk_sy_r <= 3'h0;
      cs_sy_r <= 3'h7;
      si_sy_r <= 2'h0;
    end else begin
      sclk_sy_r <= {sclk_sy_r[1:0], sclk_in};
      cs_sy_r <= {cs_sy_r[1:0], chip_select_n_in};
      si_sy_r <= {si_sy_r[0], si_in};
    end
  end

  wire cs_low = ~cs_sy_r[1];
  wire cs_rise = cs_sy_r[1] & ~cs_sy_r[2];
  wire sclk_low = ~sclk_sy_r[1];
  wire sclk_rise = sclk_sy_r[1] & ~sclk_sy_r[2];
  wire si_bit = si_sy_r[1];
  wire shift_en = cs_low & (phase_r != PH_OFF) & sclk_rise;

  // ********************************************************************
  // Byte and header decode
  // ********************************************************************
  wire byte_done = shift_en & (bitcnt_r == 3'h7);
  wire [7:0] byte_in = {sh_r, si_bit};
  wire is_hdr = byte_done & (phase_r == PH_HDR);
  wire is_data = byte_done & (phase_r == PH_DATA);
  wire hdr_rw = byte_in[HDR_RW_BIT];
  wire hdr_burst = byte_in[HDR_BURST_BIT];
  wire [5:0] hdr_addr = byte_in[5:0];
  wire hdr_is_stat = (hdr_addr >= STAT_FIRST) && (hdr_addr <= STAT_LAST);
  wire rcs_access_t hdr_acc =
    (hdr_addr <= CFG_LAST) ? AC_CFG :
    (hdr_addr == PA_ADDR) ? AC_PA :
    (hdr_addr == FIFO_ADDR) ? (hdr_rw ? AC_RXF : AC_TXF) :
    hdr_is_stat ? (hdr_burst ? AC_STAT : AC_STRB) : AC_NONE;
  wire hdr_rd = (hdr_acc == AC_STAT) ||
    (hdr_rw && (hdr_acc == AC_CFG || hdr_acc == AC_PA || hdr_acc == AC_RXF));
  wire is_strb = is_hdr & (hdr_acc == AC_STRB);
  wire [3:0] strb_code = 4'(hdr_addr - STAT_FIRST);
  wire burst_ok = (acc_r == AC_CFG) || (acc_r == AC_PA) ||
    (acc_r == AC_TXF) || (acc_r == AC_RXF);
  wire cont = burst_r & burst_ok;

  // ********************************************************************
  // Read data selection
  // ********************************************************************
  wire rcs_access_t rd_acc = is_hdr ? hdr_acc : acc_r;
  wire [5:0] rd_addr = is_hdr ? hdr_addr : addr_r + 6'h01;
  wire [2:0] rd_idx = is_hdr ? pa_idx_r : pa_idx_r + 3'h1;
  wire [3:0] stat_idx = 4'(rd_addr - STAT_FIRST);
  wire [7:0] cfg_rd = (rd_addr <= CFG_LAST) ? cfg_r[rd_addr] : 8'h00;
  wire [7:0] stat_rd = status_regs_in[stat_idx*8 +: 8];
  wire [7:0] rd_data =
    (rd_acc == AC_CFG) ? cfg_rd :
    (rd_acc == AC_STAT) ? stat_rd :
    (rd_acc == AC_PA) ? pa_r[rd_idx] :
    (rd_acc == AC_RXF && rx_rd.valid) ? rx_rd.data : 8'h00;
  wire load = (is_hdr & hdr_rd) | (is_data & cont & ~use_stat_r);
  wire rx_pop = load & (rd_acc == AC_RXF) & rx_rd.valid;

  // ********************************************************************
  // Status byte
  // ********************************************************************
  wire [FIFO_AW:0] tx_free = (FIFO_AW+1)'(FIFO_DEPTH) - tx_cnt;
  wire [FIFO_AW:0] fill = rw_r ? rx_cnt : tx_free;
  wire [3:0] stat_cnt = (fill > {3'h0, CNT_SAT}) ? CNT_SAT : fill[3:0];
  wire [7:0] status_byte = {~osc_stable_in, main_state_in, stat_cnt};
  wire so_bit = use_stat_r ? status_byte[3'h7 - bitcnt_r]
    : out_r[3'h7 - bitcnt_r];

  // ********************************************************************
  // Serial framing
  // ********************************************************************
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_r <= PH_OFF;
      acc_r <= AC_NONE;
      bitcnt_r <= 3'h0;
      sh_r <= 7'h00;
      rw_r <= 1'b0;
      burst_r <= 1'b0;
      addr_r <= 6'h00;
      use_stat_r <= 1'b1;
      out_r <= 8'h00;
      pa_idx_r <= 3'h0;
    end else if (!cs_low) begin
      phase_r <= PH_OFF;
      bitcnt_r <= 3'h0;
      use_stat_r <= 1'b1;
      pa_idx_r <= 3'h0;
    end else if (phase_r == PH_OFF) begin
      phase_r <= PH_HDR;
    end else if (shift_en) begin
      sh_r <= byte_in[6:0];
      bitcnt_r <= bitcnt_r + 3'h1;
      if (bitcnt_r == 3'h0 && phase_r == PH_HDR) begin
        rw_r <= si_bit;
      end
      if (is_hdr) begin
        acc_r <= hdr_acc;
        addr_r <= hdr_addr;
        burst_r <= hdr_burst;
        phase_r <= (hdr_acc == AC_STRB) ? PH_HDR : PH_DATA;
        use_stat_r <= ~hdr_rd;
      end
      if (is_data) begin
        addr_r <= addr_r + 6'h01;
        if (acc_r == AC_PA) begin
          pa_idx_r <= pa_idx_r + 3'h1;
        end
        if (!cont) begin
          phase_r <= PH_HDR;
          use_stat_r <= 1'b1;
        end
      end
      if (load) begin
        out_r <= rd_data;
      end
    end
  end

  // ********************************************************************
  // Configuration registers and power table
  // ********************************************************************
  wire wr_data = is_data & ~rw_r;
  wire cfg_wr = wr_data & (acc_r == AC_CFG) & (addr_r <= CFG_LAST);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < CFG_NUM; i++) begin
        cfg_r[i] <= CFG_RESET;
      end
    end else if (cfg_wr) begin
      cfg_r[addr_r] <= byte_in;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < PA_DEPTH; i++) begin
        pa_r[i] <= PA_RESET;
      end
    end else if (sleep_entry_in) begin
      for (int i = 1; i < PA_DEPTH; i++) begin
        pa_r[i] <= PA_RESET;
      end
    end else if (wr_data && acc_r == AC_PA) begin
      pa_r[pa_idx_r] <= byte_in;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CFG_NUM; g++) begin : g_cfg
      assign cfg_regs_out[g*8 +: 8] = cfg_r[g];
    end
  endgenerate

  wire [2:0] pa_sel = (ook_mode_in && ook_bit_in) ? power_entry_select_in : 3'h0;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pa_level_r <= PA_RESET;
    end else begin
      pa_level_r <= pa_r[pa_sel];
    end
  end

  // ********************************************************************
  // Strobes, flushes and transmit pushes
  // ********************************************************************
  wire flush_ok = (main_state_in == MS_IDLE) ||
    (main_state_in == MS_RX_OVERRUN) || (main_state_in == MS_TX_STARVED);
  wire strb_late = (strb_code == STRB_PDOWN) || (strb_code == STRB_OSC_OFF);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strobe_valid_r <= 1'b0;
      strobe_code_r <= 4'h0;
      pend_r <= 1'b0;
      pend_code_r <= 4'h0;
      tx_flush_r <= 1'b0;
      rx_flush_r <= 1'b0;
      tx_push_r <= 1'b0;
      tx_wdata_r <= 8'h00;
    end else begin
      strobe_valid_r <= 1'b0;
      tx_flush_r <= 1'b0;
      rx_flush_r <= 1'b0;
      tx_push_r <= wr_data & (acc_r == AC_TXF);
      if (wr_data) begin
        tx_wdata_r <= byte_in;
      end
      if (is_strb && strb_late) begin
        pend_r <= 1'b1;
        pend_code_r <= strb_code;
      end else if (is_strb) begin
        strobe_valid_r <= 1'b1;
        strobe_code_r <= strb_code;
        tx_flush_r <= (strb_code == STRB_TX_FLUSH) & flush_ok;
        rx_flush_r <= (strb_code == STRB_RX_FLUSH) & flush_ok;
      end else if (cs_rise && pend_r) begin
        strobe_valid_r <= 1'b1;
        strobe_code_r <= pend_code_r;
        pend_r <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Shared output pin
  // ********************************************************************
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      so_r <= 1'b0;
      so_oe_n_r <= 1'b1;
    end else if (cs_low) begin
      so_oe_n_r <= 1'b0;
      if (sclk_low) begin
        so_r <= so_bit;
      end
    end else begin
      so_r <= gp_level_in;
      so_oe_n_r <= gp_oe_n_in;
    end
  end

  // ********************************************************************
  // FIFOs and buffers
  // ********************************************************************
  assign spi_tx.valid = tx_push_r;
  assign spi_tx.data = tx_wdata_r;
  assign tx_out.ready = tx_ready_in;
  assign rx_in.valid = rx_valid_in;
  assign rx_in.data = rx_byte_in;
  assign rx_rd.ready = rx_pop;

  rcs_fifo u_tx_fifo (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .flush_in(tx_flush_r | sleep_entry_in),
    .wr(spi_tx),
    .rd(tx_buf),
    .count_out(tx_cnt)
  );

  rcs_skid u_tx_skid (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .in_s(tx_buf),
    .out_s(tx_out)
  );

  rcs_skid u_rx_skid (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .in_s(rx_in),
    .out_s(rx_buf)
  );

  rcs_fifo u_rx_fifo (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .flush_in(rx_flush_r | sleep_entry_in),
    .wr(rx_buf),
    .rd(rx_rd),
    .count_out(rx_cnt)
  );

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign shared_output_pin_out = so_r;
  assign shared_output_pin_oe_n_out = so_oe_n_r;
  assign strobe_valid_out = strobe_valid_r;
  assign strobe_code_out = strobe_code_r;
  assign pa_level_out = pa_level_r;
  assign rx_ready_out = rx_in.ready;
  assign tx_byte_out = tx_out.data;
  assign tx_valid_out = tx_out.valid;
endmodule

// file: verilog/rcs_pkg.sv
/*
  Shared constants and types of the radio configuration serial slave.
  Assumes nothing of its surroundings; imported by every design module.
*/
package rcs_pkg;
  // ********************************************************************
  // Widths and depths
  // ********************************************************************
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 64;
  localparam int FIFO_AW = 6;
  localparam int CFG_NUM = 47;
  localparam int STAT_NUM = 14;
  localparam int PA_DEPTH = 8;
  // ********************************************************************
  // Address map and header layout
  // ********************************************************************
  localparam logic [5:0] CFG_LAST = 6'h2E;
  localparam logic [5:0] STAT_FIRST = 6'h30;
  localparam logic [5:0] STAT_LAST = 6'h3D;
  localparam logic [5:0] PA_ADDR = 6'h3E;
  localparam logic [5:0] FIFO_ADDR = 6'h3F;
  localparam int HDR_RW_BIT = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] PA_RESET = 8'h00;
  localparam logic [3:0] CNT_SAT = 4'hF;
  // ********************************************************************
  // Strobe codes, offset from the first strobe address
  // ********************************************************************
  localparam logic [3:0] STRB_RESET = 4'h0;
  localparam logic [3:0] STRB_OSC_OFF = 4'h2;
  localparam logic [3:0] STRB_PDOWN = 4'h9;
  localparam logic [3:0] STRB_RX_FLUSH = 4'hA;
  localparam logic [3:0] STRB_TX_FLUSH = 4'hB;
  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_RX = 3'b001,
    MS_TX = 3'b010,
    MS_SYNTH_READY_TX = 3'b011,
    MS_CALIBRATE = 3'b100,
    MS_SETTLING = 3'b101,
    MS_RX_OVERRUN = 3'b110,
    MS_TX_STARVED = 3'b111
  } rcs_main_state_t;
  typedef enum logic [1:0] {
    PH_OFF = 2'b00,
    PH_HDR = 2'b01,
    PH_DATA = 2'b10
  } rcs_phase_t;
  typedef enum logic [2:0] {
    AC_NONE = 3'b000,
    AC_CFG = 3'b001,
    AC_STAT = 3'b010,
    AC_STRB = 3'b011,
    AC_PA = 3'b100,
    AC_TXF = 3'b101,
    AC_RXF = 3'b110
  } rcs_access_t;
endpackage

// file: verilog/rcs_stream_if.sv
/*
  Byte stream carrier with valid and ready.
  Assumes one clock; a word moves when valid and ready are both high.
*/
`timescale 1ns/100ps
interface rcs_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: verilog/rcs_fifo.sv
/*
  Byte FIFO with flush and fill count.
  Assumes one clock, asynchronous active-low reset; flush empties it.
*/
`timescale 1ns/100ps
module rcs_fifo
  import rcs_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW = FIFO_AW
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic flush_in,
  rcs_stream_if.snk wr,
  rcs_stream_if.src rd,
  output logic [AW:0] count_out
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  wire push = wr.valid & wr.ready;
  wire pop = rd.valid & rd.ready;

  assign count_out = wp_r - rp_r;
  assign wr.ready = (count_out != (AW+1)'(DEPTH));
  assign rd.valid = (count_out != '0);
  assign rd.data = mem[rp_r[AW-1:0]];

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (flush_in) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + (AW+1)'(1);
      end
      if (pop) begin
        rp_r <= rp_r + (AW+1)'(1);
      end
    end
  end
endmodule

// file: verilog/rcs_skid.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock; both ready and valid outputs come from flip-flops.
*/
`timescale 1ns/100ps
module rcs_skid
  import rcs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  rcs_stream_if.snk in_s,
  rcs_stream_if.src out_s
);
  logic [DATA_W-1:0] d0_r;
  logic [DATA_W-1:0] d1_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic full_r;
  logic valid_r;
  wire push = in_s.valid & ~full_r;
  wire pop = valid_r & out_s.ready;

  assign in_s.ready = ~full_r;
  assign out_s.valid = valid_r;
  assign out_s.data = d0_r;
  assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      d0_r <= '0;
      d1_r <= '0;
      cnt_r <= 2'h0;
      full_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      full_r <= (cnt_nxt == 2'h2);
      valid_r <= (cnt_nxt != 2'h0);
      if (pop) begin
        d0_r <= (push && cnt_r == 2'h1) ? in_s.data : d1_r;
        if (push && cnt_r == 2'h2) begin
          d1_r <= in_s.data;
        end
      end else if (push) begin
        if (cnt_r == 2'h0) begin
          d0_r <= in_s.data;
        end else begin
          d1_r <= in_s.data;
        end
      end
    end
  end
endmodule

// file: testbench/rcs_host_model.sv
/*
  Serial host model: mode 0 master on a 125 ns link clock.
  Assumes the slave drives its output only while select is low.
*/
`timescale 1ns/100ps
module rcs_host_model (
  output logic sclk_out,
  output logic chip_select_n_out,
  output logic si_out,
  input wire logic so_in
);
  initial begin
    sclk_out = 1'b0;
    chip_select_n_out = 1'b1;
    si_out = 1'b0;
  end
  // Bounded wait for the output to fall
  task automatic wait_low();
    for (int k = 0; k < 200 && so_in !== 1'b0; k++) #4;
    #31.25;
  endtask
  // Off the system clock edge, so the select pin never races the sampler
  task automatic sel();
    #1;
    chip_select_n_out = 1'b0;
    wait_low();
  endtask
  // Released data line stops showing its last bit
  task automatic desel();
    #31.25;
    chip_select_n_out = 1'b1;
    si_out = ~si_out;
    #250;
  endtask
  task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si_out = b[i];
      #31.25;
      sclk_out = 1'b1;
      r[i] = so_in;
      #62.5;
      sclk_out = 1'b0;
      #31.25;
    end
  endtask
endmodule

// file: testbench/rcs_spi_slave_checker.sv
/*
  Port-level assertions for the serial slave.
  Assumes one clock, mclk_in, and asynchronous active-low reset.
*/
`timescale 1ns/100ps
module rcs_spi_slave_checker
  import rcs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic sclk_in,
  input wire logic chip_select_n_in,
  input wire logic shared_output_pin_out,
  input wire logic shared_output_pin_oe_n_out,
  input wire logic gp_level_in,
  input wire logic gp_oe_n_in,
  input wire logic osc_stable_in,
  input wire logic [CFG_NUM*8-1:0] cfg_regs_out,
  input wire logic strobe_valid_out,
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);
  property p_oe_sel;
    !chip_select_n_in [*6] |-> !shared_output_pin_oe_n_out;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("pin not driven in frame");
  property p_gp_copy;
    chip_select_n_in [*6] ##0 $stable(gp_oe_n_in) && $stable(gp_level_in) |->
      shared_output_pin_oe_n_out == gp_oe_n_in && shared_output_pin_out == gp_level_in;
  endproperty
  a_gp_copy: assert property (p_gp_copy) else $error("pin not general purpose");
  property p_rdy;
    $fell(chip_select_n_in) ##1 (!chip_select_n_in && osc_stable_in) [*7] |->
      !shared_output_pin_out;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready flag not low");
  property p_stb_pulse;
    strobe_valid_out |=> !strobe_valid_out;
  endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("strobe pulse too long");
  property p_stb_when;
    strobe_valid_out |-> $past(sclk_in, 2) || $past(chip_select_n_in, 2);
  endproperty
  a_stb_when: assert property (p_stb_when) else $error("strobe at wrong time");
  property p_cfg_when;
    $changed(cfg_regs_out) |-> !$past(chip_select_n_in, 2) && $past(sclk_in, 2);
  endproperty
  a_cfg_when: assert property (p_cfg_when) else $error("config changed off byte end");
  property p_tx_hold;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx word lost in stall");
  property p_pin_hold;
    (sclk_in && !chip_select_n_in) [*6] |-> $stable(shared_output_pin_out);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("output moved, clock high");
endmodule
bind rcs_spi_slave rcs_spi_slave_checker u_chk (.*);

// file: testbench/test_radio_config_spi_slave.sv
/*
  Self-checking bench of the serial slave, driven by the host model.
  Assumes 250 MHz mclk_in and a 125 ns serial clock.
*/
`timescale 1ns/100ps
module test_radio_config_spi_slave
  import rcs_pkg::*;
;
  logic mclk_in, arst_n_in, sclk_in, chip_select_n_in, si_in;
  logic shared_output_pin_out, shared_output_pin_oe_n_out;
  logic gp_level_in = 1'b1;
  logic gp_oe_n_in = 1'b1;
  logic osc_stable_in = 1'b1;
  logic [STAT_NUM*8-1:0] status_regs_in = 112'hC3;
  logic [2:0] main_state_in, power_entry_select_in;
  logic sleep_entry_in, ook_mode_in, ook_bit_in, strobe_valid_out;
  logic [CFG_NUM*8-1:0] cfg_regs_out;
  logic [3:0] strobe_code_out;
  logic [7:0] pa_level_out, rx_byte_in, tx_byte_out, r, p;
  logic rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in;
  int failures, cmp_count, n;
  logic [7:0] txq[$];
  logic [3:0] sq[$];
  wire so = shared_output_pin_oe_n_out ? 1'b1 : shared_output_pin_out;
  rcs_spi_slave dut (.*);
  rcs_host_model u_host (.sclk_out(sclk_in), .chip_select_n_out(chip_select_n_in),
    .si_out(si_in), .so_in(so));
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (tx_valid_out && tx_ready_in) txq.push_back(tx_byte_out);
    if (strobe_valid_out) sq.push_back(strobe_code_out);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t ns got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bx(input logic [7:0] b, input logic [7:0] e);
    u_host.xfer(b, 8, r);
    chk(r, e);
  endtask
  task automatic rpush(input logic [7:0] b);
    @(posedge mclk_in);
    rx_valid_in <= 1'b1;
    rx_byte_in <= b;
    @(posedge mclk_in);
    while (rx_ready_out !== 1'b1) @(posedge mclk_in);
    rx_valid_in <= 1'b0;
  endtask
  task automatic test_done();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    test_done();
  end
  initial begin
    arst_n_in = 1'b0;
    main_state_in = MS_IDLE;
    {sleep_entry_in, ook_mode_in, ook_bit_in, rx_valid_in, tx_ready_in} = 5'h00;
    power_entry_select_in = 3'h3;
    rx_byte_in = 8'h00;
    repeat (2) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    // Oscillator not yet stable: output must stay high until it is
    osc_stable_in <= 1'b0;
    fork
      u_host.sel();
      begin
        repeat (30) @(posedge mclk_in);
        chk({7'h00, so}, 8'h01);
        osc_stable_in <= 1'b1;
      end
    join
    bx(8'h85, 8'h00);
    bx(8'h00, CFG_RESET);
    u_host.desel();
    u_host.sel();
    bx(8'h05, 8'h0F);
    bx(8'hA5, 8'h0F);
    bx(8'h6D, 8'h0F);
    bx(8'h11, 8'h0F);
    bx(8'h22, 8'h0F);
    u_host.desel();
    chk(cfg_regs_out[375:368], 8'h22);
    @(posedge mclk_in);
    main_state_in <= MS_SYNTH_READY_TX;
    u_host.sel();
    bx(8'h05, 8'h3F);
    u_host.xfer(8'h3C, 4, r);
    u_host.desel();
    chk(cfg_regs_out[47:40], 8'hA5);
    u_host.sel();
    bx(8'hED, 8'h30);
    bx(8'h00, 8'h11);
    bx(8'h00, 8'h22);
    u_host.desel();
    u_host.sel();
    bx(8'h85, 8'h30);
    bx(8'h00, 8'hA5);
    bx(8'hF0, 8'h30);
    bx(8'h00, 8'hC3);
    u_host.desel();
    @(posedge mclk_in);
    main_state_in <= MS_IDLE;
    u_host.sel();
    bx(8'h7F, 8'h0F);
    n = 0;
    for (int i = 0; i < 70; i++) begin
      u_host.xfer(i[7:0], 8, r);
      if (r[3:0] !== 4'h0) begin
        n++;
        p = r;
      end
    end
    u_host.desel();
    chk(p, 8'h01);
    chk(r, 8'h00);
    // FIFO depth plus the two-entry buffer ahead of the radio side
    chk(8'(n), 8'(FIFO_DEPTH + 2));
    @(posedge mclk_in);
    tx_ready_in <= 1'b1;
    for (int k = 0; k < 400 && txq.size() < n; k++) @(posedge mclk_in);
    chk(8'(txq.size()), 8'(n));
    for (int i = 0; i < n; i++) chk(txq[i], i[7:0]);
    rpush(8'h81);
    rpush(8'h82);
    rpush(8'h83);
    u_host.sel();
    bx(8'hBF, 8'h03);
    bx(8'h00, 8'h81);
    bx(8'hFF, 8'h02);
    bx(8'h00, 8'h82);
    bx(8'h00, 8'h83);
    u_host.desel();
    rpush(8'h84);
    @(posedge mclk_in);
    main_state_in <= MS_RX;
    u_host.sel();
    bx(8'hBA, 8'h11);
    bx(8'hBA, 8'h11);
    u_host.desel();
    @(posedge mclk_in);
    main_state_in <= MS_IDLE;
    u_host.sel();
    bx(8'hBA, 8'h01);
    bx(8'hBF, 8'h00);
    bx(8'h00, 8'h00);
    u_host.desel();
    sq.delete();
    for (int c = 0; c < 13; c++) begin
      u_host.sel();
      bx(8'h30 + c[7:0], 8'h0F);
      if (c == 0) u_host.wait_low();
      u_host.desel();
      chk(8'(sq.size()), 8'h01);
      chk(8'(sq.pop_front()), c[7:0]);
    end
    u_host.sel();
    bx(8'h7E, 8'h0F);
    for (int i = 0; i < 9; i++) bx(8'h40 + i[7:0], 8'h0F);
    u_host.desel();
    chk(pa_level_out, 8'h48);
    @(posedge mclk_in);
    {ook_mode_in, ook_bit_in} <= 2'h3;
    repeat (3) @(posedge mclk_in);
    chk(pa_level_out, 8'h43);
    for (int s = 0; s < 2; s++) begin
      u_host.sel();
      bx(8'hFE, 8'h00);
      for (int i = 0; i < 8; i++) bx(8'h00, (i == 0) ? 8'h48 : (s ? 8'h00 : 8'h40 + i[7:0]));
      u_host.desel();
      @(posedge mclk_in);
      sleep_entry_in <= 1'b1;
      @(posedge mclk_in);
      sleep_entry_in <= 1'b0;
    end
    test_done();
  end
endmodule
